// [rtl/flash_cmd_pkg.sv]
/*
 * Shared constants of the serial flash command interpreter: opcodes,
 * frame lengths, state codes, erase kinds and timing figures.
 * Assumes a 40 MHz system clock that samples every link pin.
 */
package flash_cmd_pkg;
    localparam int CLK_MHZ = 40;
    // opcodes
    localparam logic [7:0] OP_QREAD = 8'hEB;
    localparam logic [7:0] OP_QREAD_W = 8'hE7;
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_WRITE_ARM = 8'h06;
    localparam logic [7:0] OP_ENH_RESET = 8'hFF;
    localparam logic [7:0] OP_WIPE_4K = 8'h20;
    localparam logic [7:0] OP_WIPE_64K = 8'hD8;
    localparam logic [7:0] OP_WIPE_32K = 8'h52;
    localparam logic [7:0] OP_WIPE_ALL_A = 8'h60;
    localparam logic [7:0] OP_WIPE_ALL_B = 8'hC7;
    // frame lengths in link clocks
    localparam logic [5:0] CMD_BITS = 6'h08;
    localparam logic [5:0] QADDR_CLKS = 6'h06;
    localparam logic [5:0] IND_CLKS = 6'h02;
    localparam logic [5:0] DUMMY_EB = 6'h04;
    localparam logic [5:0] DUMMY_E7 = 6'h02;
    localparam logic [5:0] WRAP_BITS = 6'h08;
    localparam logic [5:0] EADDR_BITS = 6'h18;
    localparam logic [3:0] FF_CLKS = 4'h8;
    // wrap setup fields
    localparam int WRAP_OFF_BIT = 4;
    localparam logic [1:0] WRAP_DEPTH_RST = 2'h0;
    localparam logic [7:0] WRAP_MIN_MASK = 8'h07;
    // default erase times in microseconds
    localparam int SMALL_WIPE_US = 45_000;
    localparam int BLOCK_WIPE_US = 500_000;
    localparam int FULL_WIPE_US = 80_000_000;
    // erase region kinds
    typedef enum logic [1:0] {
        WK_4K = 2'h0,
        WK_32K = 2'h1,
        WK_64K = 2'h2,
        WK_ALL = 2'h3
    } wipe_kind_t;
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_CMD = 10'h002,
        S_QADDR = 10'h004,
        S_IND = 10'h008,
        S_DUMMY = 10'h010,
        S_DATA = 10'h020,
        S_WRAP = 10'h040,
        S_EADDR = 10'h080,
        S_DONE = 10'h100,
        S_SKIP = 10'h200
    } st_t;
endpackage : flash_cmd_pkg

// [rtl/wipe_timer.sv]
/*
 * Self-timed erase cycle counter: loads a cycle count on start and
 * holds busy until it runs out, then pulses done.
 * Assumes start only arrives while busy is low.
 */
`timescale 1ns/100ps
`default_nettype none
module wipe_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [WIDTH-1:0] cycles,
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic busy;
        logic done;
    } tmr_t;
    tmr_t r_reg, r_next;

    initial begin
        if (WIDTH < 2) $error("wipe_timer width too small");
    end

    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (r_reg.busy) begin
            if (r_reg.cnt <= WIDTH'(1)) begin
                r_next.busy = 1'b0;
                r_next.done = 1'b1;
            end else begin
                r_next.cnt = r_reg.cnt - WIDTH'(1);
            end
        end else if (start) begin
            r_next.busy = 1'b1;
            r_next.cnt = cycles;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign busy = r_reg.busy;
    assign done = r_reg.done;
endmodule : wipe_timer
`default_nettype wire

// [rtl/flash_cmd.sv]
/*
 * Command interpreter of a serial flash: quad read with enhance mode,
 * enhance reset, wrap setup, write arm and the four erase commands.
 * Assumes the array sits outside: it answers read_data for flash_addr in
 * the same cycle, erases on wipe_start, and reports protection hits.
 */
// How it works
// - toggling indicator nibbles keep enhance mode; next frame skips command
// - non-toggling indicator cancels enhance; next frame starts with command
// - quad read command is refused while an erase cycle runs; enhance mode frames still read
// - enhance mode entered only from quad reads EB and E7
// - in enhance mode a new frame starts with address clocks
// - FF on one line over 8 clocks leaves enhance mode
// - any equal indicator bit pair resets enhance mode
// - wrap setup 77: enable nibble 0 on, 1 off, then depth nibble
// - depth 0..3 selects 8, 16, 32 or 64 byte wrap
// - wrap region aligned inside the page; wrap off after reset
// - wrap setting held until reset; new 77 changes or disables it
// - quad reads wrap the address at the boundary when enabled
// - command 20 erases the 4K sector holding the address
// - D8 erases the 64K block, 52 the 32K block
// - 60 or C7 erases the whole array
// - address erase runs only if select rises right after 24 bits
// - erase starts and latch clears at select rise; busy until done, which also clears a latch set meanwhile
// - protected region stays intact but latch clears anyway
`timescale 1ns/100ps
`default_nettype none
module flash_cmd
    import flash_cmd_pkg::*;
#(
    // 64-bit: the whole-chip default count overflows a 32-bit int
    parameter longint SMALL_WIPE_CYC = longint'(SMALL_WIPE_US) * CLK_MHZ,
    parameter longint BLOCK_WIPE_CYC = longint'(BLOCK_WIPE_US) * CLK_MHZ,
    parameter longint FULL_WIPE_CYC = longint'(FULL_WIPE_US) * CLK_MHZ
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic select_bar,
    input wire logic link_clk,
    input wire logic [3:0] io_lines_in,
    output logic [3:0] io_lines_out,
    output logic [3:0] io_lines_oe,
    input wire logic quad_lane_on,
    input wire logic protect_scheme,
    input wire logic [3:0] protect_level,
    input wire logic level_hit,
    input wire logic lock_hit,
    input wire logic any_lock,
    output logic [23:0] flash_addr,
    input wire logic [7:0] read_data,
    output logic wipe_start,
    output logic [1:0] wipe_kind,
    output logic write_latch,
    output logic write_busy,
    output logic enhance_on,
    output logic wrap_on,
    output logic [1:0] wrap_depth
);
    typedef struct packed {
        logic sel_s1, sel_s2, sel_d;
        logic clk_s1, clk_s2, clk_d;
        logic [3:0] io_s1, io_s2;
        st_t st;
        logic [5:0] cnt;
        logic [5:0] dummy_lim;
        logic [3:0] tot;
        logic ff_ok;
        logic [7:0] sh;
        logic [23:0] addr;
        logic enh;
        logic wrap_on;
        logic [1:0] depth;
        logic latch;
        logic nib_hi;
        logic [3:0] dout;
        logic oe;
        logic go;
        wipe_kind_t kind;
    } core_t;
    core_t r_reg, r_next;

    logic busy, done;
    logic [31:0] wipe_cycles;

    initial begin
        if (SMALL_WIPE_CYC < 1 || BLOCK_WIPE_CYC < 1 || FULL_WIPE_CYC < 1)
            $error("erase times must be at least one cycle");
        if (SMALL_WIPE_CYC >= 64'h0000_0001_0000_0000
            || BLOCK_WIPE_CYC >= 64'h0000_0001_0000_0000
            || FULL_WIPE_CYC >= 64'h0000_0001_0000_0000)
            $error("erase times must fit the 32-bit timer");
    end

    // all four bit pairs differ means the nibbles are inverses
    function automatic logic toggling(input logic [7:0] b);
        toggling = &(b[7:4] ^ b[3:0]);
    endfunction : toggling

    // with wrap on keeps the upper address bits, wraps the low ones within the depth; else plain increment
    function automatic logic [23:0] next_addr(input logic [23:0] a,
                                              input logic on,
                                              input logic [1:0] d);
        logic [7:0] m;
        logic [7:0] lo;
        m = 8'((9'h008 << d) - 9'h001);
        lo = 8'(a[7:0] + 8'h01);
        if (on)
            next_addr = {a[23:8], (a[7:0] & ~m) | (lo & m)};
        else
            next_addr = 24'(a + 24'h00_0001);
    endfunction : next_addr

    logic sel_fall, sel_rise, lk_rise, lk_fall, sel_low;
    logic [7:0] byte_in;
    logic [7:0] qbyte;
    logic region_prot, chip_prot;

    assign sel_fall = r_reg.sel_d & ~r_reg.sel_s2;
    assign sel_rise = ~r_reg.sel_d & r_reg.sel_s2;
    assign sel_low = ~r_reg.sel_s2 & ~r_reg.sel_d;
    assign lk_rise = ~r_reg.clk_d & r_reg.clk_s2 & sel_low;
    assign lk_fall = r_reg.clk_d & ~r_reg.clk_s2 & sel_low;
    assign byte_in = {r_reg.sh[6:0], r_reg.io_s2[0]};
    assign qbyte = {r_reg.sh[3:0], r_reg.io_s2};
    assign region_prot = protect_scheme ? lock_hit : level_hit;
    assign chip_prot = protect_scheme ? any_lock : (protect_level != 4'h0);

    always_comb begin
        r_next = r_reg;
        r_next.go = 1'b0;
        // only the second stage of each synchroniser is read below
        r_next.sel_s1 = select_bar;
        r_next.sel_s2 = r_reg.sel_s1;
        r_next.sel_d = r_reg.sel_s2;
        r_next.clk_s1 = link_clk;
        r_next.clk_s2 = r_reg.clk_s1;
        r_next.clk_d = r_reg.clk_s2;
        r_next.io_s1 = io_lines_in;
        r_next.io_s2 = r_reg.io_s1;
        if (done) begin
            r_next.latch = 1'b0;
        end
        if (sel_fall) begin
            r_next.cnt = 6'h00;
            r_next.tot = 4'h0;
            r_next.ff_ok = 1'b1;
            r_next.st = r_reg.enh ? S_QADDR : S_CMD;
        end else if (sel_rise) begin
            r_next.st = S_IDLE;
            r_next.oe = 1'b0;
            if (r_reg.tot == FF_CLKS && r_reg.ff_ok) begin
                r_next.enh = 1'b0;
            end
            if (r_reg.st == S_EADDR && r_reg.cnt == EADDR_BITS
                && r_reg.latch && !busy) begin
                r_next.latch = 1'b0;
                r_next.go = !region_prot;
            end else if (r_reg.st == S_DONE) begin
                if (r_reg.sh == OP_WRITE_ARM) begin
                    r_next.latch = 1'b1;
                end else if ((r_reg.sh == OP_WIPE_ALL_A
                              || r_reg.sh == OP_WIPE_ALL_B)
                             && r_reg.latch && !busy) begin
                    r_next.latch = 1'b0;
                    r_next.kind = WK_ALL;
                    r_next.go = !chip_prot;
                end
            end
        end else if (lk_rise) begin
            r_next.cnt = 6'(r_reg.cnt + 6'h01);
            r_next.tot = (r_reg.tot == 4'hF) ? r_reg.tot : 4'(r_reg.tot + 4'h1);
            r_next.ff_ok = r_reg.ff_ok & r_reg.io_s2[0];
            case (r_reg.st)
                S_CMD: begin
                    r_next.sh = byte_in;
                    if (r_reg.cnt == CMD_BITS - 6'h01) begin
                        r_next.cnt = 6'h00;
                        if (byte_in == OP_QREAD || byte_in == OP_QREAD_W) begin
                            // refused reads leave the erase cycle alone
                            r_next.st = (busy || !quad_lane_on)
                                ? S_SKIP : S_QADDR;
                            r_next.dummy_lim = (byte_in == OP_QREAD_W)
                                ? DUMMY_E7 : DUMMY_EB;
                        end else if (byte_in == OP_WRAP_SET) begin
                            r_next.st = S_WRAP;
                        end else if (byte_in == OP_WIPE_4K
                                     || byte_in == OP_WIPE_64K
                                     || byte_in == OP_WIPE_32K) begin
                            r_next.st = busy ? S_SKIP : S_EADDR;
                            r_next.kind = (byte_in == OP_WIPE_4K) ? WK_4K
                                : (byte_in == OP_WIPE_32K) ? WK_32K : WK_64K;
                        end else if (byte_in == OP_WRITE_ARM
                                     || byte_in == OP_ENH_RESET
                                     || byte_in == OP_WIPE_ALL_A
                                     || byte_in == OP_WIPE_ALL_B) begin
                            r_next.st = S_DONE;
                        end else begin
                            r_next.st = S_SKIP;
                        end
                    end
                end
                S_QADDR: begin
                    r_next.addr = {r_reg.addr[19:0], r_reg.io_s2};
                    if (r_reg.cnt == QADDR_CLKS - 6'h01) begin
                        r_next.cnt = 6'h00;
                        r_next.st = S_IND;
                    end
                end
                S_IND: begin
                    r_next.sh = qbyte;
                    if (r_reg.cnt == IND_CLKS - 6'h01) begin
                        // reached only from a quad read frame
                        r_next.enh = toggling(qbyte);
                        r_next.cnt = 6'h00;
                        r_next.st = S_DUMMY;
                    end
                end
                S_DUMMY: begin
                    if (r_reg.cnt == r_reg.dummy_lim - 6'h01) begin
                        r_next.st = S_DATA;
                        r_next.nib_hi = 1'b1;
                    end
                end
                S_WRAP: begin
                    r_next.sh = byte_in;
                    if (r_reg.cnt == WRAP_BITS - 6'h01) begin
                        r_next.wrap_on = ~byte_in[WRAP_OFF_BIT];
                        if (!byte_in[WRAP_OFF_BIT]) begin
                            r_next.depth = byte_in[1:0];
                        end
                        r_next.st = S_SKIP;
                    end
                end
                S_EADDR: begin
                    r_next.addr = {r_reg.addr[22:0], r_reg.io_s2[0]};
                    // extra bits push the count past 24 and spoil the frame
                    if (r_reg.cnt > EADDR_BITS) begin
                        r_next.cnt = r_reg.cnt;
                    end
                end
                S_DONE: r_next.st = S_SKIP;
                default: r_next.cnt = r_reg.cnt;
            endcase
        end else if (lk_fall && r_reg.st == S_DATA) begin
            r_next.oe = 1'b1;
            r_next.dout = r_reg.nib_hi ? read_data[7:4] : read_data[3:0];
            r_next.nib_hi = ~r_reg.nib_hi;
            if (!r_reg.nib_hi) begin
                r_next.addr = next_addr(r_reg.addr, r_reg.wrap_on,
                                        r_reg.depth);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.sel_s1 <= 1'b1;
            r_reg.sel_s2 <= 1'b1;
            r_reg.sel_d <= 1'b1;
            r_reg.st <= S_IDLE;
            r_reg.kind <= WK_4K;
            r_reg.depth <= WRAP_DEPTH_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    always_comb begin
        case (r_reg.kind)
            WK_4K: wipe_cycles = 32'(SMALL_WIPE_CYC);
            WK_ALL: wipe_cycles = 32'(FULL_WIPE_CYC);
            default: wipe_cycles = 32'(BLOCK_WIPE_CYC);
        endcase
    end

    wipe_timer #(.WIDTH(32)) u_timer (
        .clk(clk),
        .rst(rst),
        .start(r_reg.go),
        .cycles(wipe_cycles),
        .busy(busy),
        .done(done)
    );

    assign io_lines_out = r_reg.dout;
    assign io_lines_oe = {4{r_reg.oe}};
    assign flash_addr = r_reg.addr;
    assign wipe_start = r_reg.go;
    assign wipe_kind = r_reg.kind;
    assign write_latch = r_reg.latch;
    assign write_busy = busy;
    assign enhance_on = r_reg.enh;
    assign wrap_on = r_reg.wrap_on;
    assign wrap_depth = r_reg.depth;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence frame_end_s;
        sel_rise;
    endsequence
    sequence wipe_go_s;
        r_reg.go ##1 busy;
    endsequence

    AST_ERASE_NEEDS_LATCH: assert property (
        r_reg.go |-> $past(r_reg.latch) && !r_reg.latch)
        else $error("erase started without write latch");
    AST_ERASE_STARTS_BUSY: assert property (
        frame_end_s ##1 r_reg.go |-> wipe_go_s)
        else $error("busy did not follow erase start");
    AST_LATCH_CLEAR_DONE: assert property (
        done |=> !r_reg.latch || $past(sel_rise))
        else $error("latch not cleared at erase end");
    AST_NO_START_BUSY: assert property (
        r_reg.go |-> !$past(busy))
        else $error("erase accepted while busy");
    AST_EXACT_BITS: assert property (
        r_reg.go && r_reg.kind != WK_ALL
        |-> $past(r_reg.cnt) == EADDR_BITS && $past(r_reg.st) == S_EADDR)
        else $error("erase taken with wrong bit count");
    AST_READ_REFUSED: assert property (
        lk_rise && r_reg.st == S_CMD && r_reg.cnt == 6'h07 && busy
        && (byte_in == OP_QREAD || byte_in == OP_QREAD_W)
        |=> r_reg.st == S_SKIP)
        else $error("quad read taken while busy");
    AST_ENH_ONLY_QUAD: assert property (
        $rose(r_reg.enh) |-> $past(r_reg.st) == S_IND)
        else $error("enhance entered outside quad read");
    AST_ENH_SKIPS_CMD: assert property (
        sel_fall && r_reg.enh |=> r_reg.st == S_QADDR)
        else $error("enhance frame did not start at address");
    AST_IND_DECIDES: assert property (
        lk_rise && r_reg.st == S_IND && r_reg.cnt == 6'h01
        |=> r_reg.enh == toggling($past(qbyte)))
        else $error("indicator decision wrong");
    AST_OE_IN_DATA: assert property (
        r_reg.oe |-> r_reg.st == S_DATA || $past(r_reg.st) == S_DATA)
        else $error("io driven outside data phase");
endmodule : flash_cmd
`default_nettype wire

// [dv/host_model.sv]
/* host side of the link: select, link clock, data lines, nibble read.
   assumes a 40 MHz clk; one link clock spans 8 clk (200 ns), 9 clk (225 ns) in a nibble read. */
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input wire logic clk,
    output logic select_bar,
    output logic link_clk,
    output logic [3:0] io_lines_in,
    input wire logic [3:0] io_lines_out,
    input wire logic [3:0] io_lines_oe
);
    initial begin
        select_bar = 1'b1;
        link_clk = 1'b0;
        io_lines_in = 4'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic open_frame();
        tick(1);
        select_bar <= 1'b0;
        tick(4);
    endtask : open_frame
    // link clock stands low outside frames; data changes while it is low
    task automatic nib(input logic [3:0] v);
        io_lines_in <= v;
        tick(4);
        link_clk <= 1'b1;
        tick(4);
        link_clk <= 1'b0;
    endtask : nib
    task automatic byte1(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            nib({3'h0, b[i]});
        end
    endtask : byte1
    // released lines show the inverse so a stale value cannot pass
    task automatic close_frame();
        tick(4);
        select_bar <= 1'b1;
        io_lines_in <= ~io_lines_in;
        tick(8);
    endtask : close_frame
    task automatic rd_byte(output logic [7:0] b, output logic ok);
        ok = 1'b1;
        for (int i = 1; i >= 0; i--) begin
            io_lines_in <= ~io_lines_in;
            tick(5);
            b[i*4 +: 4] = io_lines_out;
            ok = ok & (io_lines_oe === 4'hF);
            link_clk <= 1'b1;
            tick(4);
            link_clk <= 1'b0;
        end
    endtask : rd_byte
endmodule : host_model
`default_nettype wire

// [dv/tb.sv]
/* bench for flash_cmd: host model, byte array model, erase monitor,
   one task per scenario. assumes erase times shortened by parameter. */
`timescale 1ns/100ps
`default_nettype none
module tb import flash_cmd_pkg::*;;
    localparam int LONG = 2000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic select_bar, link_clk, wipe_start, write_latch, write_busy;
    logic enhance_on, wrap_on;
    logic [3:0] io_lines_in, io_lines_out, io_lines_oe;
    logic [3:0] protect_level = 4'h0;
    logic level_hit = 1'b0;
    logic quad_lane_on = 1'b1;
    logic protect_scheme = 1'b0;
    logic lock_hit = 1'b0;
    logic any_lock = 1'b0;
    logic [23:0] flash_addr, last_addr;
    logic [7:0] read_data;
    logic [1:0] wipe_kind, wrap_depth, last_kind;
    int n_fail = 0;
    int cmp_count = 0;
    int n_wipe = 0;
    int cyc = 0;
    logic oe_seen = 1'b0;
    logic enh_exp = 1'b0;
    logic wrap_exp = 1'b0;
    logic [1:0] depth_exp = 2'h0;
    flash_cmd #(.SMALL_WIPE_CYC(20), .BLOCK_WIPE_CYC(LONG),
        .FULL_WIPE_CYC(20)) u_flash_cmd (
        .clk(clk), .rst(rst), .select_bar(select_bar),
        .link_clk(link_clk), .io_lines_in(io_lines_in),
        .io_lines_out(io_lines_out), .io_lines_oe(io_lines_oe),
        .quad_lane_on(quad_lane_on), .protect_scheme(protect_scheme),
        .protect_level(protect_level), .level_hit(level_hit),
        .lock_hit(lock_hit), .any_lock(any_lock), .flash_addr(flash_addr),
        .read_data(read_data), .wipe_start(wipe_start),
        .wipe_kind(wipe_kind), .write_latch(write_latch),
        .write_busy(write_busy), .enhance_on(enhance_on),
        .wrap_on(wrap_on), .wrap_depth(wrap_depth));
    host_model host (.clk(clk), .select_bar(select_bar),
        .link_clk(link_clk), .io_lines_in(io_lines_in),
        .io_lines_out(io_lines_out), .io_lines_oe(io_lines_oe));
    // array content differs per byte so a wrong address shows
    assign read_data = flash_addr[7:0] ^ flash_addr[15:8] ^ 8'h3C;
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (io_lines_oe !== 4'h0) oe_seen <= 1'b1;
        if (wipe_start === 1'b1) begin
            n_wipe <= n_wipe + 1;
            last_kind <= wipe_kind;
            last_addr <= flash_addr;
        end
        if (cyc == 40000) begin
            n_fail = n_fail + 1;
            results();
        end
    end
    task automatic chk(input string nm, input logic [23:0] e,
            input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results
    function automatic logic [7:0] exp_byte(input logic [23:0] a,
            input int i);
        logic [23:0] m, x;
        m = wrap_exp ? (24'h8 << depth_exp) - 24'h1 : 24'hFF_FFFF;
        x = ((a + 24'(i)) & m) | (a & ~m);
        return x[7:0] ^ x[15:8] ^ 8'h3C;
    endfunction : exp_byte
    task automatic qframe(input logic [7:0] op, input logic [23:0] a,
            input logic [7:0] p, input int nb, input logic acc);
        logic [7:0] b;
        logic ok;
        oe_seen = 1'b0;
        host.open_frame();
        if (!enh_exp) host.byte1(op);
        for (int i = 5; i >= 0; i--) host.nib(a[i*4 +: 4]);
        host.nib(p[7:4]);
        host.nib(p[3:0]);
        repeat (op == OP_QREAD_W ? DUMMY_E7 : DUMMY_EB) host.nib(4'h0);
        for (int i = 0; i < nb; i++) begin
            host.rd_byte(b, ok);
            chk("read_byte", 24'(exp_byte(a, i)), 24'(b));
            chk("io_lines_oe", 24'h1, 24'(ok));
        end
        host.close_frame();
        if (acc) enh_exp = ((p[7:4] ^ p[3:0]) == 4'hF);
        else chk("oe_seen", 24'h0, 24'(oe_seen));
        chk("enhance_on", 24'(enh_exp), 24'(enhance_on));
    endtask : qframe
    task automatic cmd_frame(input logic [7:0] op, input logic [23:0] a,
            input int nbits);
        host.open_frame();
        host.byte1(op);
        for (int i = nbits - 1; i >= 0; i--) host.nib({3'h0, a[i]});
        host.close_frame();
    endtask : cmd_frame
    task automatic wait_idle();
        for (int i = 0; i < 3000 && write_busy !== 1'b0; i++) host.tick(1);
        host.tick(2);
    endtask : wait_idle
    task automatic erase_case(input logic [7:0] op, input logic [1:0] k,
            input logic [23:0] a, input logic arm, input int nbits,
            input logic prot);
        logic go;
        int w0;
        logic [23:0] m;
        go = arm && !prot && (nbits == ((k == 2'h3) ? 0 : 24));
        m = k == 2'h0 ? 24'hFF_F000 : k == 2'h1 ? 24'hFF_8000 : 24'hFF_0000;
        // under the lock scheme the level inputs claim the opposite
        lock_hit <= prot && protect_scheme;
        any_lock <= prot && protect_scheme;
        level_hit <= prot ^ protect_scheme;
        protect_level <= {3'h0, prot ^ protect_scheme};
        if (arm) begin
            cmd_frame(OP_WRITE_ARM, 24'h0, 0);
            chk("write_latch", 24'h1, 24'(write_latch));
        end
        w0 = n_wipe;
        cmd_frame(op, a, nbits);
        chk("wipe_count", 24'(w0 + go), 24'(n_wipe));
        chk("write_busy", 24'(go), 24'(write_busy));
        if (go) begin
            chk("wipe_kind", 24'(k), 24'(last_kind));
            if (k != 2'h3) chk("region", a & m, last_addr & m);
            wait_idle();
        end
        chk("write_latch", 24'(arm && !go && !prot),
            24'(write_latch));
        level_hit <= 1'b0;
        protect_level <= 4'h0;
        lock_hit <= 1'b0;
        any_lock <= 1'b0;
    endtask : erase_case
    // quad read commands with the quad lanes off are ignored
    task automatic lane_case();
        quad_lane_on <= 1'b0;
        qframe(OP_QREAD, 24'h00_0200, 8'hA5, 0, 1'b0);
        quad_lane_on <= 1'b1;
    endtask : lane_case
    // a long erase keeps busy high across three more frames
    task automatic busy_case();
        int w0;
        cmd_frame(OP_WRITE_ARM, 24'h0, 0);
        cmd_frame(OP_WIPE_64K, 24'h7F_0010, 24);
        w0 = n_wipe;
        cmd_frame(OP_WRITE_ARM, 24'h0, 0);
        cmd_frame(OP_WIPE_4K, 24'h00_1000, 24);
        chk("wipe_count", 24'(w0), 24'(n_wipe));
        qframe(OP_QREAD, 24'h00_0100, 8'hA5, 0, 1'b0);
        chk("write_busy", 24'h1, 24'(write_busy));
        wait_idle();
        chk("write_latch", 24'h0, 24'(write_latch));
    endtask : busy_case
    task automatic wrap_case();
        for (int d = 0; d < 4; d++) begin
            cmd_frame(OP_WRAP_SET, 24'(d), 8);
            wrap_exp = 1'b1;
            depth_exp = 2'(d);
            chk("wrap_on", 24'h1, 24'(wrap_on));
            chk("wrap_depth", 24'(d), 24'(wrap_depth));
            qframe(OP_QREAD, 24'h01_233E, 8'hFF, 3, 1'b1);
        end
        cmd_frame(OP_WRAP_SET, 24'h10, 8);
        wrap_exp = 1'b0;
        chk("wrap_on", 24'h0, 24'(wrap_on));
        qframe(OP_QREAD_W, 24'h01_233E, 8'h00, 3, 1'b1);
    endtask : wrap_case
    task automatic ind_case();
        logic [7:0] pv [10] = '{8'hA5, 8'h5A, 8'hFF, 8'hF0, 8'h00,
            8'h0F, 8'hAA, 8'hA5, 8'h55, 8'hA7};
        foreach (pv[i]) begin
            qframe(OP_QREAD, 24'(i * 65793), pv[i], 1, 1'b1);
        end
        qframe(OP_QREAD_W, 24'h45_6789, 8'h5A, 1, 1'b1);
        host.open_frame();
        host.byte1(OP_ENH_RESET);
        host.close_frame();
        enh_exp = 1'b0;
        chk("enhance_on", 24'h0, 24'(enhance_on));
        qframe(OP_QREAD, 24'h00_0040, 8'hFF, 1, 1'b1);
    endtask : ind_case
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk("reset_state", 24'h0, 24'({write_latch, write_busy, enhance_on,
            wrap_on, wrap_depth, io_lines_oe}));
        erase_case(OP_WIPE_4K, 2'h0, 24'h12_3456, 1'b0, 24, 1'b0);
        erase_case(OP_WIPE_4K, 2'h0, 24'h12_3456, 1'b1, 24, 1'b0);
        erase_case(OP_WIPE_32K, 2'h1, 24'h34_5678, 1'b1, 24, 1'b0);
        erase_case(OP_WIPE_64K, 2'h2, 24'h56_789A, 1'b1, 24, 1'b0);
        erase_case(OP_WIPE_ALL_A, 2'h3, 24'h0, 1'b1, 0, 1'b0);
        erase_case(OP_WIPE_ALL_B, 2'h3, 24'h0, 1'b1, 0, 1'b0);
        erase_case(OP_WIPE_4K, 2'h0, 24'h00_2000, 1'b1, 23, 1'b0);
        erase_case(OP_WIPE_4K, 2'h0, 24'h00_3000, 1'b1, 24, 1'b1);
        erase_case(OP_WIPE_ALL_B, 2'h3, 24'h0, 1'b1, 0, 1'b1);
        protect_scheme <= 1'b1;
        host.tick(1);
        erase_case(OP_WIPE_4K, 2'h0, 24'h00_5000, 1'b1, 24, 1'b1);
        erase_case(OP_WIPE_ALL_A, 2'h3, 24'h0, 1'b1, 0, 1'b1);
        erase_case(OP_WIPE_4K, 2'h0, 24'h00_6000, 1'b1, 24, 1'b0);
        protect_scheme <= 1'b0;
        host.tick(1);
        busy_case();
        lane_case();
        wrap_case();
        ind_case();
        results();
    end
endmodule : tb
`default_nettype wire
